// ==== common/aof_pkg.sv ====
package aof_pkg;

    // operand and shifter widths
    localparam int DATA_W  = 16;
    localparam int SHIFT_W = 32;
    localparam int SUM_W   = DATA_W + 1;

    // apb geometry and register byte addresses
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;
    localparam logic [APB_AW-1:0] REG_CTRL   = 8'h00;
    localparam logic [APB_AW-1:0] REG_OPND_A = 8'h04;
    localparam logic [APB_AW-1:0] REG_OPND_B = 8'h08;
    localparam logic [APB_AW-1:0] REG_SUM    = 8'h0C;
    localparam logic [APB_AW-1:0] REG_RESULT = 8'h10;
    localparam logic [APB_AW-1:0] REG_ENABLE = 8'h14;

    // field positions and reset values
    localparam int CTRL_FREEZE_BIT = 0;
    localparam int SUM_CARRY_BIT   = 16;
    localparam int EN_FCR_BIT      = 11;
    localparam logic              CTRL_FREEZE_RST = 1'b0;
    localparam logic              FCR_RST         = 1'b0;
    localparam logic [DATA_W-1:0] OPND_RST        = 16'h0000;
    localparam logic [APB_DW-1:0] APB_ZERO        = 32'h0000_0000;

    // constant generator masks
    localparam logic [DATA_W-1:0] BYTE_MASK = 16'h00FF;
    localparam logic [DATA_W-1:0] NYB_MASK  = 16'h000F;

    // extra micro-cycles held off after a bit sense or sense/toggle
    localparam int STALL_W            = 2;
    localparam int SENSE_STALL_CYCLES = 1;

    // micro-instructions seen by the operand front end
    typedef enum logic [4:0] {
        nop_op, sum_op, double_sum_op, or_op, and_op,
        shift_op, shift_right_op, double_left_shift_op, double_right_shift_op,
        d_to_a_op, d_to_a_comp_op, index_op, d_to_a_variant_op,
        load_a_word_op, load_a_word_complement_op, load_a_byte_op, clear_load_a_op,
        load_b_word_op, load_b_word_complement_op, load_b_low_op,
        load_d_op, load_d_comp_op, load_s_op, invoke_op,
        bit_sense_op, sense_toggle_op, const_op
    } aof_op_t;

    // constant generator size
    typedef enum logic [1:0] {csize_word, csize_byte, csize_nybble} aof_csize_t;

    // store form of an operand register
    typedef enum logic [1:0] {store_none, store_true, store_comp} aof_store_t;

endpackage

// ==== design/aof_fanin.sv ====
// Decided for this implementation: the APB register port and the register addresses.
module aof_fanin
    import aof_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                nrst,

    // apb slave
    input  wire logic [APB_AW-1:0]   paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [APB_DW-1:0]   pwdata,
    output logic      [APB_DW-1:0]   prdata,
    output logic                     pready,
    output logic                     pslverr,

    // current micro-instruction
    input  wire aof_op_t             uop,
    input  wire aof_csize_t          const_size,
    input  wire logic [DATA_W-1:0]   const_lit,
    input  wire logic                a_designator,
    input  wire logic                b_designator,

    // sources, all in complement form
    input  wire logic [SHIFT_W-1:0]  shifter_n,
    input  wire logic [DATA_W-1:0]   toggle_bit_source_n,
    input  wire logic [DATA_W-1:0]   dreg_n,
    input  wire logic [DATA_W-1:0]   extended_file_n,
    input  wire logic [DATA_W-1:0]   basic_file_n,
    input  wire logic [DATA_W-1:0]   b_sum_source_n,

    // operands and results
    output logic      [DATA_W-1:0]   operand_a,
    output logic      [DATA_W-1:0]   operand_b,
    output logic      [DATA_W-1:0]   sum_q,
    output logic                     carry_q,
    output logic                     a_eq_b_q,
    output logic      [DATA_W-1:0]   result_q,
    output logic                     result_valid_q,
    output logic                     forced_carry_reg,
    output logic                     stall,

    // control storage interface
    output logic      [DATA_W-1:0]   file_to_control_if_out,
    output logic                     load_s_stb_q,
    output logic                     load_d_stb_q
);

    // micro-instruction classes
    wire is_shift;
    wire is_dta;
    wire is_load_d;
    wire is_bfile_op;
    wire is_bitop;
    wire is_toggle;
    wire a_file_op;

    // permits and source enables
    wire both_designators_set;
    wire invoke_file_select;
    wire ext_permit;
    wire shifter_to_operand_en;
    wire dreg_to_a_en;
    wire toggle_to_a_en;
    wire ext_file_to_a_en;
    wire basic_file_to_a_en;
    wire ext_file_to_b_en;
    wire basic_file_to_b_en;
    wire bsum_to_b_en;
    wire const_to_b_en;
    wire a_any_en;
    wire b_any_en;

    // store control
    aof_store_t a_store;
    aof_store_t b_store;
    wire a_true_store_en;
    wire a_complement_store_en;
    wire b_true_store_en;
    wire b_complement_store_en;
    wire a_load;
    wire b_load;

    // datapath
    wire [DATA_W-1:0] const_word;
    wire [DATA_W-1:0] const_n;
    wire [DATA_W-1:0] a_fanin;
    wire [DATA_W-1:0] b_fanin;
    wire [SUM_W-1:0]  sum_full;
    wire [DATA_W-1:0] logic_or;
    wire [DATA_W-1:0] logic_and;
    wire              fcr_d;
    wire              result_take;
    wire [DATA_W-1:0] result_d;

    // registers
    logic               freeze_q;
    logic [STALL_W-1:0] stall_cnt_q;
    logic [APB_DW-1:0]  prdata_q;
    logic               pslverr_q;

    // bus decode
    wire              apb_setup;
    wire              apb_write;
    wire              addr_hit;
    wire [APB_DW-1:0] rd_data;
    wire [11:0]       en_vec;

    // store form per micro-instruction
    function automatic logic [3:0] store_decode(input aof_op_t op);
        aof_store_t sa;
        aof_store_t sb;
        sa = store_none;
        sb = store_none;
        unique case (op)
            shift_op, shift_right_op, double_left_shift_op, double_right_shift_op,
            d_to_a_op, index_op, load_a_byte_op, clear_load_a_op:
            begin
                sa = store_true;
                sb = store_true;
            end
            d_to_a_comp_op, load_a_word_op:
                sa = store_true;
            d_to_a_variant_op:
            begin
                sa = store_comp;
                sb = store_true;
            end
            load_a_word_complement_op:
                sa = store_comp;
            load_b_word_op, load_b_low_op, load_d_op, bit_sense_op, const_op:
                sb = store_true;
            load_b_word_complement_op, load_d_comp_op:
                sb = store_comp;
            sense_toggle_op:
            begin
                sa = store_true;
                sb = store_true;
            end
            nop_op, sum_op, double_sum_op, or_op, and_op, load_s_op, invoke_op:
            begin
                sa = store_none;
                sb = store_none;
            end
        endcase
        return {sa, sb};
    endfunction

    // classify the executing micro-instruction
    assign is_shift    = uop inside {shift_op, shift_right_op,
                                     double_left_shift_op, double_right_shift_op};
    assign is_dta      = uop inside {d_to_a_op, d_to_a_comp_op, index_op,
                                     d_to_a_variant_op};
    assign is_load_d   = uop inside {load_d_op, load_d_comp_op};
    assign is_bfile_op = (uop inside {load_b_word_op, load_b_word_complement_op,
                                      load_a_byte_op, clear_load_a_op,
                                      load_b_low_op}) | is_load_d;
    assign is_bitop    = uop inside {bit_sense_op, sense_toggle_op};
    assign is_toggle   = (uop == sense_toggle_op);
    assign a_file_op   = !is_load_d && !is_shift && !is_dta && !is_toggle;

    // file permit
    assign both_designators_set = a_designator & b_designator;
    assign invoke_file_select   = (uop == invoke_op);
    assign ext_permit           = both_designators_set | invoke_file_select;

    // A side source enables
    assign shifter_to_operand_en = is_shift;
    assign dreg_to_a_en          = is_dta;
    assign toggle_to_a_en        = is_toggle;
    assign ext_file_to_a_en      = ext_permit & a_file_op;
    assign basic_file_to_a_en    = !ext_permit & a_file_op;

    // B side source enables
    assign ext_file_to_b_en   = ext_permit & is_bfile_op;
    assign basic_file_to_b_en = !ext_permit & is_bfile_op;
    assign bsum_to_b_en       = is_bitop;
    assign const_to_b_en      = !(is_shift || is_bfile_op || is_bitop);

    assign a_any_en = shifter_to_operand_en | dreg_to_a_en | toggle_to_a_en
                    | ext_file_to_a_en | basic_file_to_a_en;
    assign b_any_en = shifter_to_operand_en | ext_file_to_b_en | basic_file_to_b_en
                    | bsum_to_b_en | const_to_b_en;

    // true and complement store enables
    assign {a_store, b_store}    = store_decode(uop);
    assign a_true_store_en       = (a_store == store_true);
    assign a_complement_store_en = (a_store == store_comp);
    assign b_true_store_en       = (b_store == store_true);
    assign b_complement_store_en = (b_store == store_comp);

    // a register loads only with a source and a store form; frozen by software
    assign a_load = a_any_en && (a_true_store_en || a_complement_store_en)
                 && !freeze_q;
    assign b_load = b_any_en && (b_true_store_en || b_complement_store_en)
                 && !freeze_q;

    // constant generator, width set by the micro-instruction
    assign const_word = (const_size == csize_byte)   ? (const_lit & BYTE_MASK) :
                        (const_size == csize_nybble) ? (const_lit & NYB_MASK)  :
                        const_lit;
    assign const_n    = ~const_word;

    // A fan-in: inverted sources gated by true enables give true data
    assign a_fanin = ({DATA_W{shifter_to_operand_en}} & ~shifter_n[SHIFT_W-1:DATA_W])
                   | ({DATA_W{dreg_to_a_en}}          & ~dreg_n)
                   | ({DATA_W{toggle_to_a_en}}        & ~toggle_bit_source_n)
                   | ({DATA_W{ext_file_to_a_en}}      & ~extended_file_n)
                   | ({DATA_W{basic_file_to_a_en}}    & ~basic_file_n);

    // B fan-in, low half of the shifter lands here
    assign b_fanin = ({DATA_W{shifter_to_operand_en}} & ~shifter_n[DATA_W-1:0])
                   | ({DATA_W{ext_file_to_b_en}}      & ~extended_file_n)
                   | ({DATA_W{basic_file_to_b_en}}    & ~basic_file_n)
                   | ({DATA_W{bsum_to_b_en}}          & ~b_sum_source_n)
                   | ({DATA_W{const_to_b_en}}         & ~const_n);

    // A operand register
    aof_operand_reg #(
        .WIDTH (DATA_W)
    ) u_opnd_a (
        .clk  (clk),
        .nrst (nrst),
        .load (a_load),
        .comp (a_complement_store_en),
        .d    (a_fanin),
        .q    (operand_a)
    );

    // B operand register
    aof_operand_reg #(
        .WIDTH (DATA_W)
    ) u_opnd_b (
        .clk  (clk),
        .nrst (nrst),
        .load (b_load),
        .comp (b_complement_store_en),
        .d    (b_fanin),
        .q    (operand_b)
    );

    // adder always runs on the held operands plus the forced carry
    assign sum_full = {1'b0, operand_a} + {1'b0, operand_b}
                    + {{DATA_W{1'b0}}, forced_carry_reg};
    assign logic_or  = operand_a | operand_b;
    assign logic_and = operand_a & operand_b;

    // forced carry: set by complement word loads, chained by double sum
    assign fcr_d = (uop inside {load_a_word_complement_op,
                                load_b_word_complement_op}) ? 1'b1 :
                   (uop == double_sum_op) ? sum_full[SUM_CARRY_BIT] :
                   (uop == sum_op)        ? 1'b0 :
                   forced_carry_reg;

    // result selection only when the micro-instruction takes it
    assign result_take = uop inside {sum_op, double_sum_op, or_op, and_op};
    assign result_d    = (uop == or_op)  ? logic_or  :
                         (uop == and_op) ? logic_and :
                         sum_full[DATA_W-1:0];

    // forced carry register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            forced_carry_reg <= FCR_RST;
        else
            forced_carry_reg <= fcr_d;
    end

    // unconditional sum and compare
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sum_q    <= OPND_RST;
            carry_q  <= 1'b0;
            a_eq_b_q <= 1'b0;
        end
        else
        begin
            sum_q    <= sum_full[DATA_W-1:0];
            carry_q  <= sum_full[SUM_CARRY_BIT];
            a_eq_b_q <= (operand_a == operand_b);
        end
    end

    // selected result
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            result_q       <= OPND_RST;
            result_valid_q <= 1'b0;
        end
        else
        begin
            result_q       <= result_take ? result_d : result_q;
            result_valid_q <= result_take;
        end
    end

    // hold off the next step after the long bit sense path
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            stall_cnt_q <= '0;
        else if (is_bitop)
            stall_cnt_q <= STALL_W'(SENSE_STALL_CYCLES);
        else if (stall_cnt_q != '0)
            stall_cnt_q <= stall_cnt_q - STALL_W'(1);
    end

    assign stall = (stall_cnt_q != '0);

    // basic file word to the control storage interface
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            file_to_control_if_out <= OPND_RST;
            load_s_stb_q           <= 1'b0;
            load_d_stb_q           <= 1'b0;
        end
        else
        begin
            if ((uop == load_s_op) || is_load_d)
                file_to_control_if_out <= ~basic_file_n;
            load_s_stb_q <= (uop == load_s_op);
            load_d_stb_q <= is_load_d;
        end
    end

    // apb decode
    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pwrite;
    assign addr_hit  = paddr inside {REG_CTRL, REG_OPND_A, REG_OPND_B,
                                     REG_SUM, REG_RESULT, REG_ENABLE};

    // enable snapshot for software
    assign en_vec = {forced_carry_reg, const_to_b_en, bsum_to_b_en,
                     basic_file_to_b_en, ext_file_to_b_en, basic_file_to_a_en,
                     ext_file_to_a_en, toggle_to_a_en, dreg_to_a_en,
                     shifter_to_operand_en, a_load, b_load};

    // read mux, reserved bits read zero
    assign rd_data = (paddr == REG_CTRL)   ? {31'h0000_0000, freeze_q}        :
                     (paddr == REG_OPND_A) ? {16'h0000, operand_a}            :
                     (paddr == REG_OPND_B) ? {16'h0000, operand_b}            :
                     (paddr == REG_SUM)    ? {15'h0000, carry_q, sum_q}       :
                     (paddr == REG_RESULT) ? {15'h0000, result_valid_q, result_q} :
                     (paddr == REG_ENABLE) ? {20'h0_0000, en_vec}             :
                     APB_ZERO;

    // read data and error captured in the setup cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            prdata_q  <= APB_ZERO;
            pslverr_q <= 1'b0;
        end
        else if (apb_setup)
        begin
            prdata_q  <= pwrite ? APB_ZERO : rd_data;
            pslverr_q <= ~addr_hit;
        end
    end

    // control register, written in the access cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            freeze_q <= CTRL_FREEZE_RST;
        else if (apb_write && (paddr == REG_CTRL))
            freeze_q <= pwdata[CTRL_FREEZE_BIT];
    end

    // zero wait answers
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q & penable;
    assign pready  = 1'b1;

endmodule

// ==== design/aof_operand_reg.sv ====
module aof_operand_reg
    import aof_pkg::*;
#(
    parameter int WIDTH = DATA_W
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // store control
    input  wire logic             load,
    input  wire logic             comp,
    input  wire logic [WIDTH-1:0] d,
    // held operand
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] cond;
    logic [WIDTH-1:0] q_d;

    // preset for complement form, preclear for true form
    assign cond = comp ? {WIDTH{1'b1}} : {WIDTH{1'b0}};

    // a one on the data toggles the conditioned stage
    assign q_d = load ? (cond ^ d) : q;

    // operand flip-flops
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            q <= '0;
        else
            q <= q_d;
    end

endmodule

// ==== verif/aof_fanin_sva.sv ====
module aof_fanin_chk
    import aof_pkg::*;
(
    // clock and reset
    input wire logic               clk,
    input wire logic               nrst,
    // micro-instruction side
    input wire aof_op_t            uop,
    input wire aof_csize_t         const_size,
    input wire logic [DATA_W-1:0]  const_lit,
    input wire logic               a_designator,
    input wire logic               b_designator,
    input wire logic [SHIFT_W-1:0] shifter_n,
    input wire logic [DATA_W-1:0]  dreg_n,
    input wire logic [DATA_W-1:0]  basic_file_n,
    // operand side
    input wire logic [DATA_W-1:0]  operand_a,
    input wire logic [DATA_W-1:0]  operand_b,
    input wire logic [DATA_W-1:0]  result_q,
    input wire logic               result_valid_q,
    input wire logic               forced_carry_reg,
    input wire logic               stall
);
    timeunit 1ns;
    timeprecision 1ps;
    wire both_set = a_designator && b_designator;

    // all checks on the one micro-cycle clock
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // loads land in true or complement form from the right source
    a_shift_both: assert property (
        uop inside {shift_op, shift_right_op, double_left_shift_op, double_right_shift_op}
        |=> {operand_a, operand_b} == ~$past(shifter_n)) else $error("shift not held");
    a_dreg_true: assert property (
        uop == d_to_a_op |=> operand_a == ~$past(dreg_n)) else $error("dreg to A wrong");
    a_basic_b: assert property (
        uop == load_b_word_op && !both_set |=> operand_b == ~$past(basic_file_n))
        else $error("basic file to B wrong");
    a_comp_b: assert property (
        uop == load_b_word_complement_op && !both_set
        |=> operand_b == $past(basic_file_n) && forced_carry_reg) else $error("comp store wrong");
    a_const_nyb: assert property (
        uop == const_op && const_size == csize_nybble
        |=> operand_b == ($past(const_lit) & NYB_MASK)) else $error("nybble wrong");
    a_hold_nop: assert property (
        uop == nop_op |=> $stable(operand_a) && $stable(operand_b)) else $error("operand moved");
    // results and hold-off
    a_sum_res: assert property (
        uop == sum_op |=> result_valid_q
        && result_q == $past(operand_a) + $past(operand_b) + $past(forced_carry_reg))
        else $error("sum wrong");
    a_stall_one: assert property (
        uop inside {bit_sense_op, sense_toggle_op} |=> stall ##1 !stall) else $error("stall");
endmodule

bind aof_fanin aof_fanin_chk u_chk (.clk, .nrst, .uop, .const_size, .const_lit, .a_designator,
    .b_designator, .shifter_n, .dreg_n, .basic_file_n, .operand_a, .operand_b, .result_q,
    .result_valid_q, .forced_carry_reg, .stall);

// ==== verif/aof_useq_model.sv ====
module aof_useq_model
    import aof_pkg::*;
(
    // clock and hold-off
    input  wire logic               clk,
    input  wire logic               stall,
    // current micro-instruction
    output aof_op_t                 uop,
    output aof_csize_t              const_size,
    output logic      [DATA_W-1:0]  const_lit,
    output logic                    a_designator,
    output logic                    b_designator,
    // sources, complement form
    output logic      [SHIFT_W-1:0] shifter_n,
    output logic      [DATA_W-1:0]  toggle_bit_source_n,
    output logic      [DATA_W-1:0]  dreg_n,
    output logic      [DATA_W-1:0]  extended_file_n,
    output logic      [DATA_W-1:0]  basic_file_n,
    output logic      [DATA_W-1:0]  b_sum_source_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] v;

    // each source but the constant a distinct image of one word so a wrong pick shows; the constant matches the basic file
    assign const_lit           = v;
    assign basic_file_n        = ~v;
    assign extended_file_n     = v;
    assign dreg_n              = ~(v ^ 16'h0F0F);
    assign toggle_bit_source_n = ~(v ^ 16'h3333);
    assign b_sum_source_n      = ~(v ^ 16'h00FF);
    assign shifter_n           = ~{v ^ 16'hAAAA, v ^ 16'h5555};

    // idle at start
    initial
    begin
        uop          = nop_op;
        const_size   = csize_word;
        a_designator = 1'b0;
        b_designator = 1'b0;
        v            = 16'h0000;
    end

    // one micro-instruction for one cycle, held off while stalled
    task automatic issue(input aof_op_t op, input logic [DATA_W-1:0] val,
                         input logic ad = 1'b0, input logic bd = 1'b0,
                         input aof_csize_t cs = csize_word);
        int n;
        n = 0;
        while (stall !== 1'b0 && n < 8)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 8)
            test_aof_fanin.report_and_stop(1'b1);
        @(posedge clk);
        uop          <= op;
        v            <= val;
        const_size   <= cs;
        a_designator <= ad;
        b_designator <= bd;
        @(posedge clk);
        uop <= nop_op;
        v   <= ~val; // released sources show the inverse word
        #1;
    endtask
endmodule

// ==== verif/test_aof_fanin.sv ====
module test_aof_fanin
    import aof_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk, nrst, psel, penable, pwrite, pready, pslverr, slv, a_eq_b_q;
    logic              carry_q, result_valid_q, forced_carry_reg, stall, a_designator;
    logic              b_designator, load_s_stb_q, load_d_stb_q;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata, prdata, rd;
    logic [DATA_W-1:0] operand_a, operand_b, sum_q, result_q, file_to_control_if_out, w;
    logic [DATA_W-1:0] const_lit, toggle_bit_source_n, dreg_n, extended_file_n;
    logic [DATA_W-1:0] basic_file_n, b_sum_source_n;
    logic [SHIFT_W-1:0] shifter_n;
    aof_op_t           uop;
    aof_csize_t        const_size;
    int                err_count = 0;
    int                tests_run = 0;
    aof_op_t    sh[4] = '{shift_op, shift_right_op, double_left_shift_op, double_right_shift_op};
    aof_op_t    da[4] = '{d_to_a_op, d_to_a_comp_op, index_op, d_to_a_variant_op};
    aof_csize_t cs[3] = '{csize_word, csize_byte, csize_nybble};
    logic [DATA_W-1:0] mk[3] = '{16'hFFFF, BYTE_MASK, NYB_MASK};

    aof_fanin dut (.clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .uop, .const_size, .const_lit, .a_designator, .b_designator, .shifter_n,
        .toggle_bit_source_n, .dreg_n, .extended_file_n, .basic_file_n, .b_sum_source_n,
        .operand_a, .operand_b, .sum_q, .carry_q, .a_eq_b_q, .result_q, .result_valid_q,
        .forced_carry_reg, .stall, .file_to_control_if_out, .load_s_stb_q, .load_d_stb_q);
    aof_useq_model u_seq (.clk, .stall, .uop, .const_size, .const_lit, .a_designator,
        .b_designator, .shifter_n, .toggle_bit_source_n, .dreg_n, .extended_file_n,
        .basic_file_n, .b_sum_source_n);

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // verdict and end of run
    task automatic report_and_stop(input logic bad);
        err_count += bad;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // compare seen against expected
    task automatic chk(input logic [APB_DW:0] got, input logic [APB_DW:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // one apb transfer; read data and error taken at the completing edge
    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1 && ++n < 9);
        {rd, slv} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (n == 9)
            report_and_stop(1'b1);
    endtask

    // main sequence
    initial
    begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        u_seq.issue(load_b_word_complement_op, 16'h1234);
        chk(operand_b, 16'hEDCB);
        chk(forced_carry_reg, 1'b1);
        u_seq.issue(load_a_word_op, 16'h5678);
        u_seq.issue(sum_op, 16'h0000);
        chk({result_valid_q, result_q}, {1'b1, 16'h4444});
        chk({carry_q, forced_carry_reg, sum_q}, {2'b10, 16'h4444});
        u_seq.issue(or_op, 16'h0000);
        chk({operand_a, result_q}, {16'h5678, 16'hFFFB});
        foreach (sh[i])
        begin
            w = 16'h0101 << i;
            u_seq.issue(sh[i], w);
            chk({operand_a, operand_b}, {w ^ 16'hAAAA, w ^ 16'h5555});
        end
        foreach (da[i])
        begin
            w = 16'h1010 << i;
            u_seq.issue(da[i], w);
            chk(operand_a, (i == 3) ? DATA_W'(~(w ^ 16'h0F0F)) : w ^ 16'h0F0F);
        end
        u_seq.issue(load_b_word_op, 16'h2222, 1'b1, 1'b1);
        chk(operand_b, 16'hDDDD);
        u_seq.issue(load_b_word_op, 16'h2222, 1'b1, 1'b0);
        chk(operand_b, 16'h2222);
        u_seq.issue(load_a_word_op, 16'h3333, 1'b1, 1'b1);
        chk(operand_a, 16'hCCCC);
        foreach (cs[i])
        begin
            u_seq.issue(const_op, 16'hABCD, 1'b0, 1'b0, cs[i]);
            chk(operand_b, 16'hABCD & mk[i]);
        end
        u_seq.issue(bit_sense_op, 16'h0004);
        chk({stall, operand_b}, {1'b1, 16'h00FB});
        u_seq.issue(load_s_op, 16'h4321);
        chk({load_s_stb_q, file_to_control_if_out}, {1'b1, 16'h4321});
        // load d moves the word to B and to the control storage side
        u_seq.issue(load_d_op, 16'h5A5A);
        chk({load_d_stb_q, operand_b, file_to_control_if_out}, {1'b1, 16'h5A5A, 16'h5A5A});
        // equal operands show on the compare one edge after the load
        u_seq.issue(load_a_word_op, 16'h5A5A);
        u_seq.issue(nop_op, 16'h0000);
        chk(a_eq_b_q, 1'b1);
        // freeze refuses loads; unmapped address flags an error
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        u_seq.issue(load_a_word_op, 16'h7777);
        chk(operand_a, 16'h5A5A);
        apb(1'b0, REG_CTRL, APB_ZERO);
        chk(rd, 32'h0000_0001);
        apb(1'b1, REG_CTRL, APB_ZERO);
        apb(1'b0, 8'h40, APB_ZERO);
        chk({slv, rd}, {1'b1, APB_ZERO});
        report_and_stop(1'b0);
    end
endmodule
